/* File: verilog/gir_status_regs.v */
`timescale 1ns/100ps
`include "gir_consts.vh"
// What this block does
// (RQ1) Identification top bit shows the future-use jumper.
// (RQ2) Identification low seven bits hold a fixed card code.
// (RQ3) Built-in variant leaves identification register undriven.
// (RQ4) Interrupt status top bit shows interrupts enabled.
// (RQ5) Bit six shows the card requesting service.
// (RQ6) Bits five and four show switch interrupt level 3 to 6.
// (RQ7) Bits one and zero show DMA channel enables; bits three, two unused.
// (RQ8) Built-in variant leaves most bits out, level fixed at 3.
// (RQ9) Controller top bit is system controller; bit six is not active controller.
// (RQ10) Low five bits give primary address switch, 0 to 30.
// (RQ11) Built-in variant leaves controller bits five to zero out.
// (RQ12) Reading either cause register or data lines alters interface state.
// (RQ13) First cause bits seven and six summarise pending causes.
// (RQ14) First cause bit five byte received, bit four ready for next.
// (RQ15) First cause bit three on EOI with ATN false.
// (RQ16) First cause bits: serial poll addressed, remote/local change, address change.
// (RQ17) Second cause bits: trigger, handshake error, unrecognised command.
// (RQ18) Second cause bits: secondary address, device clear entry.
// (RQ19) Second cause bits: own address, service request, interface clear.
// (RQ20) Interface state: REM, LLO, ATN, LPAS, TPAS, LADS, TADS, address LSB.
// (RQ21) Control-line register shows live bus lines, one for asserted.
// (RQ22) NDAC, NRFD valid only when talker; SRQ only when controller. The register passes all three raw, unqualified.
// (RQ23) Interrupt raised only for causes whose mask bit is set.
module gir_status_regs #(
    parameter       BUILT_IN  = 0,
    parameter [6:0] CARD_CODE = 7'h2a  // Arbitrary identification value
) (
    // Clock and reset
    input  wire       clock,
    input  wire       rst_n,
    // Host read port
    input  wire       readStrobe,
    input  wire [4:0] readAddr,
    output reg  [7:0] readData_q,
    output reg        readValid_q,
    // Straps and switches
    input  wire       futureJumper,
    input  wire [1:0] intLevelSwitch,
    input  wire [4:0] primaryAddrSwitch,
    input  wire       systemController,
    // Enables from the write side
    input  wire       intrEnable,
    input  wire       dma_channel_one_on,
    input  wire       dma_channel_zero_on,
    input  wire [5:0] maskHigh,
    input  wire [7:0] maskLow,
    // Interface function state
    input  wire       activeController,
    input  wire       remoteState,
    input  wire       localLockout,
    input  wire       listenPrimary,
    input  wire       talkPrimary,
    input  wire       listenAddressed,
    input  wire       talkAddressed,
    input  wire       serialPollAddressed,
    input  wire       deviceClearActive,
    input  wire       lastAddrLsb,
    input  wire       myAddrChange,
    // Interface events, one-cycle pulses
    input  wire       byteReceived,
    input  wire       readyForByte,
    input  wire       triggerReceived,
    input  wire       handshakeError,
    input  wire       unknownCommand,
    input  wire       secondaryReceived,
    input  wire       myAddrReceived,
    input  wire       srqReceived,
    input  wire       ifcReceived,
    // Live bus lines, high means asserted
    input  wire       lineAtn,
    input  wire       lineDav,
    input  wire       lineNdac,
    input  wire       lineNrfd,
    input  wire       lineEoi,
    input  wire       lineSrq,
    input  wire       lineIfc,
    input  wire       lineRen,
    input  wire [7:0] dataLines,
    input  wire [7:0] passThrough,
    // Side effects and interrupt
    output reg        dataLinesRead_q,
    output reg        serviceRequest_q
);
    wire [8:0] addrSel;
    wire [8:0] rdOh;
    wire       clrHigh;
    wire       clrLow;
    wire [5:0] highEvents;
    wire [7:0] lowEvents;
    wire [5:0] highCause;
    wire [7:0] lowCause;
    wire [2:0] levelRise;
    wire       levelChange;
    wire       endSeen;
    wire       highPending;
    wire       lowPending;
    reg  [7:0] readMux;

    // One-hot select of the nine mapped offsets; feeds both clears and mux
    function [8:0] regSelect;
        input [4:0] addr;
        begin
            regSelect = 9'h000;
            case (addr)
                `GIR_OFF_CARD_ID:      regSelect = 9'h001;
                `GIR_OFF_INTR_DMA:     regSelect = 9'h002;
                `GIR_OFF_CTRL_ADDR:    regSelect = 9'h004;
                `GIR_OFF_CAUSE_HIGH:   regSelect = 9'h008;
                `GIR_OFF_CAUSE_LOW:    regSelect = 9'h010;
                `GIR_OFF_BUS_STATE:    regSelect = 9'h020;
                `GIR_OFF_CTRL_LINES:   regSelect = 9'h040;
                `GIR_OFF_PASS_THROUGH: regSelect = 9'h080;
                `GIR_OFF_DATA_LINES:   regSelect = 9'h100;
                default:               regSelect = 9'h000;
            endcase
        end
    endfunction

    assign addrSel = regSelect(readAddr);
    assign rdOh    = {9{readStrobe}} & addrSel;
    assign clrHigh = rdOh[3]; // [RQ12]
    assign clrLow  = rdOh[4]; // [RQ12]

    // Level-sourced causes: edges of state, not the states themselves
    gir_edge_detect #(
        .WIDTH (3)
    ) uEdges (
        .clock   (clock),
        .rst_n   (rst_n),
        .levels  ({deviceClearActive, serialPollAddressed, lineEoi & ~lineAtn}),
        .rises   (levelRise),
        .changes ()
    );

    gir_edge_detect #(
        .WIDTH (1)
    ) uChanges (
        .clock   (clock),
        .rst_n   (rst_n),
        .levels  (remoteState),
        .rises   (),
        .changes (levelChange)
    );

    assign endSeen = levelRise[0]; // [RQ15]

    assign highEvents = {byteReceived,          // [RQ14]
                         readyForByte,          // [RQ14]
                         endSeen,               // [RQ15]
                         levelRise[1],          // [RQ16]
                         levelChange,           // [RQ16]
                         myAddrChange};         // [RQ16]

    assign lowEvents = {triggerReceived,        // [RQ17]
                        handshakeError,         // [RQ17]
                        unknownCommand,         // [RQ17]
                        secondaryReceived,      // [RQ18]
                        levelRise[2],           // [RQ18]
                        myAddrReceived,         // [RQ19]
                        srqReceived,            // [RQ19]
                        ifcReceived};           // [RQ19]

    gir_cause_bank #(
        .WIDTH (6)
    ) uHigh (
        .clock       (clock),
        .rst_n       (rst_n),
        .setEvents   (highEvents),
        .clearOnRead (clrHigh),
        .causes_q    (highCause)
    );

    gir_cause_bank #(
        .WIDTH (8)
    ) uLow (
        .clock       (clock),
        .rst_n       (rst_n),
        .setEvents   (lowEvents),
        .clearOnRead (clrLow),
        .causes_q    (lowCause)
    );

    // Summary bits count only unmasked causes
    assign highPending = |(highCause & maskHigh); // [RQ13] [RQ23]
    assign lowPending  = |(lowCause & maskLow);   // [RQ13] [RQ23]

    // Register bytes, one field to a line
    wire [7:0] cardIdByte;
    wire [7:0] intrDmaByte;
    wire [7:0] ctrlAddrByte;
    wire [7:0] causeHighByte;
    wire [7:0] causeLowByte;
    wire [7:0] busStateByte;
    wire [7:0] ctrlLinesByte;

    // Variant is fixed at elaboration, so no mux is left for it
    generate
        if (BUILT_IN == 0) begin : gExternal
            assign cardIdByte   = {futureJumper,             // [RQ1]
                                   CARD_CODE};               // [RQ2]
            assign intrDmaByte  = {intrEnable,               // [RQ4]
                                   serviceRequest_q,         // [RQ5]
                                   intLevelSwitch,           // [RQ6]
                                   2'b00,                    // [RQ7]
                                   dma_channel_one_on,       // [RQ7]
                                   dma_channel_zero_on};     // [RQ7]
            assign ctrlAddrByte = {systemController,         // [RQ9]
                                   ~activeController,        // [RQ9]
                                   1'b0,                     // [RQ10]
                                   primaryAddrSwitch};       // [RQ10]
        end else begin : gBuiltIn
            // Undriven register; all ones stands for whatever floats
            assign cardIdByte   = `GIR_FLOAT_BYTE;           // [RQ3]
            assign intrDmaByte  = {1'b0,                     // [RQ8]
                                   serviceRequest_q,         // [RQ5]
                                   2'b00,                    // [RQ8]
                                   2'b00,                    // [RQ8]
                                   1'b0,                     // [RQ8]
                                   dma_channel_zero_on};     // [RQ7]
            assign ctrlAddrByte = {systemController,         // [RQ9]
                                   ~activeController,        // [RQ9]
                                   6'h00};                   // [RQ11]
        end
    endgenerate

    assign causeHighByte = {highPending,                     // [RQ13]
                            lowPending,                      // [RQ13]
                            highCause};                      // [RQ14] [RQ15] [RQ16]
    assign causeLowByte  = lowCause;                         // [RQ17] [RQ18] [RQ19]
    assign busStateByte  = {remoteState,                     // [RQ20]
                            localLockout,                    // [RQ20]
                            lineAtn,                         // [RQ20]
                            listenPrimary,                   // [RQ20]
                            talkPrimary,                     // [RQ20]
                            listenAddressed,                 // [RQ20]
                            talkAddressed,                   // [RQ20]
                            lastAddrLsb};                    // [RQ20]
    // Qualified bits are passed raw; software must mask them
    assign ctrlLinesByte = {lineAtn,                         // [RQ21]
                            lineDav,                         // [RQ21]
                            lineNdac,                        // [RQ21] [RQ22]
                            lineNrfd,                        // [RQ21] [RQ22]
                            lineEoi,                         // [RQ21]
                            lineSrq,                         // [RQ21] [RQ22]
                            lineIfc,                         // [RQ21]
                            lineRen};                        // [RQ21]

    // Unmapped offsets select nothing and read as zero
    always @* begin
        readMux = ({8{addrSel[0]}} & cardIdByte)
                | ({8{addrSel[1]}} & intrDmaByte)
                | ({8{addrSel[2]}} & ctrlAddrByte)
                | ({8{addrSel[3]}} & causeHighByte)
                | ({8{addrSel[4]}} & causeLowByte)
                | ({8{addrSel[5]}} & busStateByte)
                | ({8{addrSel[6]}} & ctrlLinesByte)
                | ({8{addrSel[7]}} & passThrough)
                | ({8{addrSel[8]}} & dataLines);
    end

    always @(posedge clock) begin
        if (!rst_n) begin
            readData_q       <= `GIR_RESET_BYTE;
            readValid_q      <= 1'b0;
            dataLinesRead_q  <= 1'b0;
            serviceRequest_q <= 1'b0;
        end else begin
            readValid_q      <= readStrobe;
            dataLinesRead_q  <= rdOh[8]; // [RQ12]
            serviceRequest_q <= intrEnable & (highPending | lowPending); // [RQ5] [RQ23]
            if (readStrobe) begin
                readData_q <= readMux;
            end
        end
    end
endmodule // gir_status_regs

/* File: pkg/gir_consts.vh */
`ifndef GIR_CONSTS_VH
`define GIR_CONSTS_VH
// Register offsets (byte addresses on the host port)
`define GIR_OFF_CARD_ID        5'h01
`define GIR_OFF_INTR_DMA       5'h03
`define GIR_OFF_CTRL_ADDR      5'h05
`define GIR_OFF_CAUSE_HIGH     5'h11
`define GIR_OFF_CAUSE_LOW      5'h13
`define GIR_OFF_BUS_STATE      5'h15
`define GIR_OFF_CTRL_LINES     5'h17
`define GIR_OFF_PASS_THROUGH   5'h1d
`define GIR_OFF_DATA_LINES     5'h1f
// Field positions
`define GIR_ID_JUMPER_BIT      7
`define GIR_CAUSE_HIGH_SUM     7
`define GIR_CAUSE_LOW_SUM      6
// Reset value of read data, and the byte read from an undriven register
`define GIR_RESET_BYTE         8'h00
`define GIR_FLOAT_BYTE         8'hff
`endif

/* File: verilog/gir_cause_bank.v */
`timescale 1ns/100ps
// Sticky cause byte: set wins over read-clear
module gir_cause_bank #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             clock,
    input  wire             rst_n,
    // Events and clear
    input  wire [WIDTH-1:0] setEvents,
    input  wire             clearOnRead,
    // State
    output reg  [WIDTH-1:0] causes_q
);
    wire [WIDTH-1:0] causes_d;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : gBit
            // Event in the read cycle survives, so no cause is lost
            assign causes_d[i] = setEvents[i] | (causes_q[i] & ~clearOnRead);
        end
    endgenerate
    always @(posedge clock) begin
        if (!rst_n) begin
            causes_q <= {WIDTH{1'b0}};
        end else begin
            causes_q <= causes_d;
        end
    end
endmodule // gir_cause_bank

/* File: verilog/gir_edge_detect.v */
`timescale 1ns/100ps
// One-cycle pulses on rise or any change of a level vector
module gir_edge_detect #(
    parameter WIDTH = 2
) (
    // Clock and reset
    input  wire             clock,
    input  wire             rst_n,
    // Levels
    input  wire [WIDTH-1:0] levels,
    // Pulses
    output wire [WIDTH-1:0] rises,
    output wire [WIDTH-1:0] changes
);
    reg [WIDTH-1:0] prev_q;
    always @(posedge clock) begin
        if (!rst_n) begin
            prev_q <= {WIDTH{1'b0}};
        end else begin
            prev_q <= levels;
        end
    end
    assign rises   = levels & ~prev_q;
    assign changes = levels ^ prev_q;
endmodule // gir_edge_detect

/* File: verif/gir_status_regs_checker.sv */
`timescale 1ns/100ps
module gir_status_regs_checker #(
    parameter       BUILT_IN  = 0,
    parameter [6:0] CARD_CODE = 7'h2a
) (
    // Clock and reset
    input wire       clock,
    input wire       rst_n,
    // Host read port
    input wire       readStrobe,
    input wire [4:0] readAddr,
    input wire [7:0] readData_q,
    input wire       readValid_q,
    // Straps and enables
    input wire       futureJumper,
    input wire [1:0] intLevelSwitch,
    input wire       intrEnable,
    input wire       dma_channel_one_on,
    input wire       dma_channel_zero_on,
    // Bus side
    input wire       byteReceived,
    input wire       ifcReceived,
    input wire [7:0] dataLines,
    // Results
    input wire       dataLinesRead_q,
    input wire       serviceRequest_q
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    a_read_answer: assert property (readStrobe |=> readValid_q) else $error("no answer");
    a_id_jumper: assert property (!BUILT_IN && readStrobe && readAddr == 5'h01 |=>
        readData_q[7] == $past(futureJumper)) else $error("jumper bit");
    a_id_code: assert property (!BUILT_IN && readStrobe && readAddr == 5'h01 |=>
        readData_q[6:0] == CARD_CODE) else $error("card code");
    a_intr_dma: assert property (!BUILT_IN && readStrobe && readAddr == 5'h03 |=>
        {readData_q[7], readData_q[5:4], readData_q[1:0]} == {$past(intrEnable),
        $past(intLevelSwitch), $past(dma_channel_one_on), $past(dma_channel_zero_on)})
        else $error("status byte");
    a_data_lines: assert property (readStrobe && readAddr == 5'h1f |=>
        readData_q == $past(dataLines) && dataLinesRead_q) else $error("data lines");
    a_srq_gate: assert property (!intrEnable |=> !serviceRequest_q)
        else $error("request while disabled");
    a_byte_cause: assert property (byteReceived ##1 !readStrobe ##1
        readStrobe && readAddr == 5'h11 |=> readData_q[5]) else $error("byte cause");
    a_ifc_cause: assert property (ifcReceived ##1 !readStrobe [*2] ##1
        readStrobe && readAddr == 5'h13 |=> readData_q[0]) else $error("clear cause");
endmodule // gir_status_regs_checker

bind gir_status_regs gir_status_regs_checker #(.BUILT_IN(BUILT_IN), .CARD_CODE(CARD_CODE))
    u_chk (.*);

/* File: verif/gir_bus_model.sv */
`timescale 1ns/100ps
// Far bus as the card sees it; a one is an asserted line
module gir_bus_model (
    // Levels asked for by the bench
    input  wire [7:0] linePat,
    input  wire [7:0] dataPat,
    // Control lines
    output wire       lineAtn,
    output wire       lineDav,
    output wire       lineNdac,
    output wire       lineNrfd,
    output wire       lineEoi,
    output wire       lineSrq,
    output wire       lineIfc,
    output wire       lineRen,
    // Data lines and held command
    output wire [7:0] dataLines,
    output wire [7:0] passThrough
);
    assign {lineAtn, lineDav, lineNdac, lineNrfd, lineEoi, lineSrq, lineIfc, lineRen} =
        linePat;
    // Handshake and SRQ lines move regardless of talker state; reader passes them raw
    assign dataLines = dataPat;
    assign passThrough = dataPat;
endmodule // gir_bus_model

/* File: verif/gir_status_regs_test.sv */
`timescale 1ns/100ps
module gir_status_regs_test;
    typedef struct packed {logic [4:0] a; logic [7:0] p; logic [7:0] e;} gir_row_t;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic       readStrobe = 1'b0;
    logic [4:0] readAddr = 5'h00;
    logic [7:0] pat = 8'h00;
    logic [5:0] evHi = 6'h00;
    logic [7:0] evLo = 8'h00;
    logic [5:0] maskHigh = 6'h3f;
    logic [7:0] maskLow = 8'hff;
    logic       intrEnable = 1'b0;
    int         miscompares = 0;
    int         num_checks = 0;
    wire  [7:0] readData_q, dataLines, passThrough;
    wire        readValid_q, dataLinesRead_q, serviceRequest_q;
    wire  [7:0] intData;
    wire        lineAtn, lineDav, lineNdac, lineNrfd, lineEoi, lineSrq, lineIfc, lineRen;
    wire        futureJumper, systemController, activeController, localLockout;
    wire        dma_channel_one_on, dma_channel_zero_on;
    wire  [1:0] intLevelSwitch;
    wire  [4:0] primaryAddrSwitch = pat[4:0];
    wire        listenPrimary, talkPrimary, listenAddressed, talkAddressed, lastAddrLsb;
    wire        byteReceived, readyForByte, serialPollAddressed, remoteState, myAddrChange;
    wire        triggerReceived, handshakeError, unknownCommand, secondaryReceived;
    wire        deviceClearActive, myAddrReceived, srqReceived, ifcReceived;
    gir_row_t   rows [14] = '{
        {5'h01, 8'h80, 8'haa}, {5'h01, 8'h00, 8'h2a}, {5'h03, 8'h66, 8'h33},
        {5'h03, 8'h24, 8'h12}, {5'h05, 8'h1e, 8'h9e}, {5'h05, 8'h00, 8'h40},
        {5'h15, 8'h95, 8'h75}, {5'h15, 8'h0a, 8'h0a}, {5'h17, 8'ha5, 8'ha5},
        {5'h17, 8'h5a, 8'h5a}, {5'h1d, 8'h3c, 8'h3c}, {5'h1f, 8'hc3, 8'hc3},
        {5'h00, 8'hff, 8'h00}, {5'h1e, 8'h00, 8'h00}};
    // One pattern moves straps, states and lines together
    assign {futureJumper, intLevelSwitch, systemController, activeController,
            dma_channel_one_on, dma_channel_zero_on, localLockout} = pat;
    assign {listenPrimary, talkPrimary, listenAddressed, talkAddressed, lastAddrLsb} = pat[4:0];
    assign {byteReceived, readyForByte, serialPollAddressed, remoteState, myAddrChange} =
        {evHi[5:4], evHi[2:0]};
    assign {triggerReceived, handshakeError, unknownCommand, secondaryReceived,
            deviceClearActive, myAddrReceived, srqReceived, ifcReceived} = evLo;

    always #2.5 clock = ~clock;

    gir_status_regs u_dut (.*);
    // Built-in variant sees the same stimulus; only its read byte is compared
    gir_status_regs #(.BUILT_IN(1)) u_dut_int (.readData_q(intData), .readValid_q(),
        .dataLinesRead_q(), .serviceRequest_q(), .*);
    // End condition for cause bit three comes from the bus EOI line
    gir_bus_model u_bus (.linePat(pat | {4'h0, evHi[3], 3'h0}), .dataPat(pat), .*);

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        @(negedge clock);
        readStrobe = 1'b1;
        readAddr = a;
        @(negedge clock);
        readStrobe = 1'b0;
        check({7'h00, readValid_q}, 8'h01);
        check(readData_q, e);
    endtask

    task automatic pulse(input logic [5:0] h, input logic [7:0] l);
        @(negedge clock);
        evHi = h;
        evLo = l;
        @(negedge clock);
        evHi = 6'h00;
        evLo = 8'h00;
        @(negedge clock);
    endtask

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        foreach (rows[i]) begin
            pat = rows[i].p;
            rdc(rows[i].a, rows[i].e);
        end
        pat = 8'h66;
        rdc(5'h03, 8'h33);
        check(intData, 8'h01);
        rdc(5'h01, 8'h2a);
        check(intData, 8'hff);
        pat = 8'h1e;
        rdc(5'h05, 8'h9e);
        check(intData, 8'h80);
        pat = 8'h00;
        rdc(5'h11, 8'h88);
        rdc(5'h11, 8'h00);
        $display("Register table done");
        for (int i = 0; i < 6; i++) begin
            pulse(6'h01 << i, 8'h00);
            rdc(5'h11, 8'h80 | (8'h01 << i));
            rdc(5'h11, 8'h00);
        end
        $display("First cause register done");
        intrEnable = 1'b1;
        for (int i = 0; i < 8; i++) begin
            pulse(6'h00, 8'h01 << i);
            check({7'h00, serviceRequest_q}, 8'h01);
            rdc(5'h13, 8'h01 << i);
            rdc(5'h13, 8'h00);
        end
        pulse(6'h00, 8'h02);
        rdc(5'h11, 8'h40);
        rdc(5'h03, 8'hc0);
        maskLow = 8'h00;
        rdc(5'h11, 8'h00);
        check({7'h00, serviceRequest_q}, 8'h00);
        rdc(5'h13, 8'h02);
        maskLow = 8'hff;
        maskHigh = 6'h1f;
        pulse(6'h20, 8'h00);
        check({7'h00, serviceRequest_q}, 8'h00);
        rdc(5'h11, 8'h20);
        maskHigh = 6'h3f;
        $display("Second cause register done");
        @(negedge clock);
        readStrobe = 1'b1;
        readAddr = 5'h11;
        evHi = 6'h20;
        @(negedge clock);
        readStrobe = 1'b0;
        evHi = 6'h00;
        check(readData_q, 8'h00);
        rdc(5'h11, 8'ha0);
        pulse(6'h00, 8'h80);
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        check({7'h00, serviceRequest_q}, 8'h00);
        rdc(5'h13, 8'h00);
        $display("Set priority and reset done");
        give_verdict;
    end

    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        give_verdict;
    end
endmodule // gir_status_regs_test
